// [core/bas_pkg.sv]
// Shared constants, types and decode helpers for the burst address sequencer.
package bas_pkg;

  // Command-address word layout, as it arrives over the eight-bit link.
  localparam int CA_W = 48;
  localparam logic [2:0] CA_BYTES = 3'h6;
  localparam int CA_BURST_BIT = 45;
  localparam int CA_UPPER_HI = 44;
  localparam int CA_UPPER_LO = 16;
  localparam int CA_LOWER_HI = 2;
  localparam int FULL_ADDR_W = 32;

  // APB register byte offsets.
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;

  // Access configuration word: reset value and field positions.
  localparam logic [15:0] CFG_RST = 16'h8f1f;
  localparam int CFG_HYB_DIS_BIT = 2;
  localparam int WRAP_LEN_HI = 1;
  localparam int WRAP_LEN_LO = 0;

  // Wrap-length field codes.
  localparam logic [1:0] WRAP_128 = 2'h0;
  localparam logic [1:0] WRAP_64 = 2'h1;
  localparam logic [1:0] WRAP_16 = 2'h2;
  localparam logic [1:0] WRAP_32 = 2'h3;

  // Word-offset masks; a word is two bytes, so a group has half as many words as bytes.
  localparam int MASK_W = 7;
  localparam logic [6:0] MASK_128 = 7'h3f;
  localparam logic [6:0] MASK_64 = 7'h1f;
  localparam logic [6:0] MASK_16 = 7'h07;
  localparam logic [6:0] MASK_32 = 7'h0f;

  // Status register bit positions.
  localparam int STAT_BURST_BIT = 0;
  localparam int STAT_LINEAR_BIT = 1;
  localparam int STAT_HYBRID_BIT = 2;
  localparam int STAT_TYPE_BIT = 3;

  typedef enum logic [1:0] {BAS_IDLE, BAS_CMD, BAS_BURST} bas_state_e;

  // Wrap-length field to word-offset mask.
  function automatic logic [6:0] wrap_mask(input logic [1:0] f);
    logic [6:0] m;
    m = MASK_32;
    case (f)
      WRAP_128: m = MASK_128;
      WRAP_64: m = MASK_64;
      WRAP_16: m = MASK_16;
      default: m = MASK_32;
    endcase
    return m;
  endfunction

  // Word address carried by a command-address word.
  function automatic logic [31:0] ca_word_addr(input logic [47:0] ca);
    return {ca[CA_UPPER_HI:CA_UPPER_LO], ca[CA_LOWER_HI:0]};
  endfunction

endpackage

// [core/bas_sync.sv]
// Two-flop synchroniser for pins that arrive from outside the pclk domain.
module bas_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // A zero-width synchroniser has nothing to carry.
  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  // Reset to the idle level of each pin, so no false edge or select follows reset.
  // The first stage is read by the second stage only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

// [core/bas_next_addr.sv]
// Next word address of a burst: wrap inside the group, hybrid exit, or linear increment.
module bas_next_addr #(
  parameter int ADDR_W = 32
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [ADDR_W-1:0] base,
  input wire logic [6:0] mask,
  input wire logic [6:0] cnt,
  input wire logic linear,
  input wire logic hybrid,
  output logic [ADDR_W-1:0] nxt,
  output logic go_linear
);
  logic [ADDR_W-1:0] mask_w;
  logic [ADDR_W-1:0] inc;

  // Only the offset bits move during the wrap; the group base stays fixed.
  always_comb begin
    mask_w = {{(ADDR_W-7){1'b0}}, mask};
    inc = ADDR_W'(addr + 1'b1);
    go_linear = 1'b0;
    if (linear) begin
      nxt = inc;
    end else if (hybrid && cnt == mask) begin
      nxt = ADDR_W'(base + mask_w + 1'b1);
      go_linear = 1'b1;
    end else begin
      nxt = base | (inc & mask_w);
    end
  end
endmodule

// [core/bas_top.sv]
// Burst address sequencer: link front end, word address stepping and APB registers.
// How it works
// - Wrapped groups are 16, 32, 64 or 128 bytes, and the size sets both length and alignment.
// - A wrapped burst stays inside the aligned group that holds the addressed word until a hybrid exit.
// - A wrap starts at the addressed word, runs to the group's end, then from its first word back.
// - Hybrid mode does exactly one full wrap of the group and then never wraps again.
// - After that wrap a hybrid burst counts up linearly until chip select goes high.
// - The linear phase starts at the first word of the group after the wrapped one.
// - The hybrid-disable bit resets to one; one gives legacy wrap, zero gives hybrid order.
// - With burst type zero the low three configuration bits pick hybrid or wrap and the size.
// - Addresses count 16-bit words, so a group has half as many words as bytes.
// - The wrap-length field codes 00,01,10,11 as 128,64,16,32 bytes and resets to 11.
//
// The implementer's own choices: the APB register port and the register offsets.
module bas_top
  import bas_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_cs_n,
  input wire logic link_ck,
  input wire logic [7:0] link_dq,
  output logic [ADDR_W-1:0] word_addr,
  output logic addr_valid,
  output logic addr_step,
  output logic burst_linear
);
  import bas_pkg::*;

  // Parameter sanity: the address must hold a 128-byte group and fit the command word.
  if (ADDR_W < 8 || ADDR_W > FULL_ADDR_W) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  // Pin synchronisers; the idle level of chip select is high.
  logic [9:0] pins_s;
  bas_sync #(.W(10), .RST_VAL(10'h200)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({link_cs_n, link_ck, link_dq}),
    .dout(pins_s)
  );

  logic cs_n_s;
  logic ck_s;
  logic [7:0] dq_s;
  assign cs_n_s = pins_s[9];
  assign ck_s = pins_s[8];
  assign dq_s = pins_s[7:0];

  // Edge finder on the synchronised link clock.
  logic ck_prev_q;
  logic ck_rise;
  logic ck_edge;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
    end
  end
  assign ck_rise = ck_s & ~ck_prev_q;
  assign ck_edge = ck_s ^ ck_prev_q;

  // Configuration state.
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;

  // Sequencer state.
  bas_state_e st_q;
  bas_state_e st_d;
  logic [47:0] ca_q;
  logic [47:0] ca_d;
  logic [2:0] nb_q;
  logic [2:0] nb_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] base_d;
  logic [6:0] mask_q;
  logic [6:0] mask_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic lin_q;
  logic lin_d;
  logic hyb_q;
  logic hyb_d;
  logic type_q;
  logic type_d;
  logic valid_q;
  logic valid_d;
  logic step_q;
  logic step_d;
  logic ca_done;

  logic [ADDR_W-1:0] nxt_addr;
  logic go_lin;
  logic [ADDR_W-1:0] mask_w;
  logic [FULL_ADDR_W-1:0] start_full;
  assign mask_w = {{(ADDR_W-7){1'b0}}, mask_q};

  bas_next_addr #(.ADDR_W(ADDR_W)) u_next (
    .addr(addr_q),
    .base(base_q),
    .mask(mask_q),
    .cnt(cnt_q),
    .linear(lin_q),
    .hybrid(hyb_q),
    .nxt(nxt_addr),
    .go_linear(go_lin)
  );

  // Link sequencer: collect the six command bytes, then step one word per link clock rise.
  // Configuration is sampled once per burst so a mid-burst write cannot tear the sequence.
  always_comb begin
    st_d = st_q;
    ca_d = ca_q;
    nb_d = nb_q;
    addr_d = addr_q;
    base_d = base_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    lin_d = lin_q;
    hyb_d = hyb_q;
    type_d = type_q;
    valid_d = valid_q;
    step_d = 1'b0;
    ca_done = 1'b0;
    start_full = ca_word_addr(ca_q);
    if (cs_n_s) begin
      st_d = BAS_IDLE;
      valid_d = 1'b0;
      nb_d = 3'h0;
    end else begin
      case (st_q)
        BAS_IDLE: begin
          st_d = BAS_CMD;
          nb_d = 3'h0;
        end
        BAS_CMD: begin
          if (ck_edge) begin
            ca_d = {ca_q[39:0], dq_s};
            nb_d = 3'(nb_q + 1'b1);
            if (nb_q == 3'(CA_BYTES - 1'b1)) begin
              ca_done = 1'b1;
              start_full = ca_word_addr(ca_d);
              addr_d = start_full[ADDR_W-1:0];
              mask_d = wrap_mask(cfg_q[WRAP_LEN_HI:WRAP_LEN_LO]);
              base_d = start_full[ADDR_W-1:0] & ~{{(ADDR_W-7){1'b0}}, mask_d};
              type_d = ca_d[CA_BURST_BIT];
              lin_d = ca_d[CA_BURST_BIT];
              hyb_d = ~cfg_q[CFG_HYB_DIS_BIT];
              cnt_d = 7'h00;
              valid_d = 1'b1;
              st_d = BAS_BURST;
            end
          end
        end
        BAS_BURST: begin
          if (ck_rise) begin
            addr_d = nxt_addr;
            cnt_d = 7'(cnt_q + 1'b1);
            step_d = 1'b1;
            if (go_lin) begin
              lin_d = 1'b1;
            end
          end
        end
        default: st_d = BAS_IDLE;
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= BAS_IDLE;
      ca_q <= '0;
      nb_q <= 3'h0;
      addr_q <= '0;
      base_q <= '0;
      mask_q <= MASK_32;
      cnt_q <= 7'h00;
      lin_q <= 1'b0;
      hyb_q <= 1'b0;
      type_q <= 1'b0;
      valid_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ca_q <= ca_d;
      nb_q <= nb_d;
      addr_q <= addr_d;
      base_q <= base_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      lin_q <= lin_d;
      hyb_q <= hyb_d;
      type_q <= type_d;
      valid_q <= valid_d;
      step_q <= step_d;
    end
  end

  assign word_addr = addr_q;
  assign addr_valid = valid_q;
  assign addr_step = step_q;
  assign burst_linear = lin_q;

  // APB slave: no wait states, answer registered so every bus output leaves a flip-flop.
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic mapped;
  logic [31:0] rd_mux;
  always_comb begin
    cfg_d = cfg_q;
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == CFG_OFS) begin
      rd_mux = {16'h0000, cfg_q};
    end else if (paddr == ADDR_OFS) begin
      rd_mux = FULL_ADDR_W'(addr_q);
    end else if (paddr == STAT_OFS) begin
      rd_mux[STAT_BURST_BIT] = (st_q == BAS_BURST);
      rd_mux[STAT_LINEAR_BIT] = lin_q;
      rd_mux[STAT_HYBRID_BIT] = hyb_q;
      rd_mux[STAT_TYPE_BIT] = type_q;
    end else begin
      mapped = 1'b0;
    end
    pready_d = psel & ~penable;
    prdata_d = (psel & ~penable & ~pwrite) ? rd_mux : prdata;
    pslverr_d = psel & ~penable & ~mapped;
    if (psel && penable && pready && pwrite && paddr == CFG_OFS) begin
      cfg_d = pwdata[15:0];
    end
  end

  // APB registers; the configuration word returns to its documented reset value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Checks on the address sequence.
  property p_in_group;
    (st_q == BAS_BURST && !lin_q) |-> ((addr_q & ~mask_w) == base_q);
  endproperty
  a_in_group: assert property (p_in_group) else $error("wrap left its group");

  property p_wrap_turn;
    (step_d && !lin_q && !go_lin && ((addr_q & mask_w) == mask_w)) |=> (addr_q == $past(base_q));
  endproperty
  a_wrap_turn: assert property (p_wrap_turn) else $error("wrap did not return to group start");

  property p_wrap_step;
    (step_d && !lin_q && !go_lin) |=> ((addr_q & mask_w) == (ADDR_W'($past(addr_q) + 1'b1) & mask_w))
      && ((addr_q & ~mask_w) == ($past(addr_q) & ~mask_w));
  endproperty
  a_wrap_step: assert property (p_wrap_step) else $error("wrap step moved upper bits");

  property p_exit_full;
    go_lin |-> (hyb_q && cnt_q == mask_q && !lin_q);
  endproperty
  a_exit_full: assert property (p_exit_full) else $error("hybrid exit before a full wrap");

  property p_exit_addr;
    (step_d && go_lin) |=> (lin_q && addr_q == ADDR_W'($past(base_q) + $past(mask_w) + 1'b1));
  endproperty
  a_exit_addr: assert property (p_exit_addr) else $error("linear phase started at wrong word");

  property p_lin_inc;
    (step_d && lin_q) |=> (addr_q == ADDR_W'($past(addr_q) + 1'b1)) ##1 lin_q || cs_n_s;
  endproperty
  a_lin_inc: assert property (p_lin_inc) else $error("linear step not one word");

  property p_end;
    cs_n_s |=> (!addr_valid && st_q == BAS_IDLE);
  endproperty
  a_end: assert property (p_end) else $error("burst outlived chip select");

  property p_legacy;
    (st_q == BAS_BURST && !hyb_q && !type_q) |-> !lin_q;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy wrap went linear");

  property p_type_lin;
    ca_done |=> (lin_q == $past(ca_d[CA_BURST_BIT])) && (type_q == $past(ca_d[CA_BURST_BIT]))
      && (hyb_q == !$past(cfg_q[CFG_HYB_DIS_BIT]));
  endproperty
  a_type_lin: assert property (p_type_lin) else $error("burst type or mode not taken");

  property p_mask;
    ca_done |=> (mask_q == wrap_mask($past(cfg_q[WRAP_LEN_HI:WRAP_LEN_LO])));
  endproperty
  a_mask: assert property (p_mask) else $error("group size decode wrong");

endmodule

// [dv/bas_host_model.sv]
// Host controller model that frames bursts on the link pins.
module bas_host_model (
  output logic cs_n,
  output logic ck,
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;

  // The link clock stands still outside frames and chip select idles high.
  initial begin
    cs_n = 1'b1;
    ck = 1'b0;
    dq = 8'h5a;
  end

  // Opens a frame and sends six command bytes, MSB byte first, one per clock edge.
  // The 13 ns offset keeps link edges away from pclk edges so sampling never races.
  task automatic open_burst(input logic [47:0] ca);
    #13;
    cs_n = 1'b0;
    #200;
    for (int i = 5; i >= 0; i--) begin
      dq = ca[i*8 +: 8];
      #100;
      ck = ~ck;
      #100;
    end
    dq = ~dq; // Released data shows the inverse, not the last byte.
    #100;
  endtask

  // One full link clock period; the device steps once on the rising half.
  task automatic step();
    #13;
    ck = 1'b1;
    dq = ~dq;
    #200;
    ck = 1'b0;
    dq = ~dq;
    #200;
  endtask

  // Ends the frame by raising chip select with the clock parked low.
  task automatic close_burst();
    #13;
    cs_n = 1'b1;
    dq = ~dq;
    #100;
  endtask
endmodule

// [dv/bas_top_tb.sv]
// Self-checking testbench for the burst address sequencer.
module bas_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bas_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, word_addr;
  logic link_cs_n, link_ck, addr_valid, addr_step, burst_linear;
  logic [7:0] link_dq;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] ofs_tab [8] = '{8'h03, 8'h2e, 8'h0c, 8'h1e, 8'h03, 8'h2e, 8'h0c, 8'h0a};

  bas_top #(.ADDR_W(32)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_cs_n(link_cs_n), .link_ck(link_ck), .link_dq(link_dq),
    .word_addr(word_addr), .addr_valid(addr_valid), .addr_step(addr_step), .burst_linear(burst_linear));

  bas_host_model u_host (.cs_n(link_cs_n), .ck(link_ck), .dq(link_dq));

  // A 50 ns system clock.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic timeout(input string what);
    num_errors++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    give_verdict();
  endtask

  // One APB transfer; entered just after a rising edge, left just after one.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Waits, bounded, until addr_valid reaches the given level.
  task automatic wait_av(input logic lvl);
    int i;
    for (i = 0; i < 40; i++) begin
      if (addr_valid === lvl) break;
      @(posedge pclk);
    end
    if (i == 40) timeout("addr_valid");
  endtask

  // Waits, bounded, for one step pulse.
  task automatic wait_step();
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (addr_step === 1'b1) break;
    end
    if (i == 40) timeout("addr_step");
  endtask

  // Configures, runs one burst a group plus five words long, and checks every address.
  task automatic run(input logic [2:0] code, input logic lin, input logic [7:0] ofs);
    logic [31:0] r, ex, base, msk, st;
    logic e, hyb, done;
    int cnt;
    msk = (code[1:0] == 2'h0) ? 32'h3f : (code[1:0] == 2'h1) ? 32'h1f : (code[1:0] == 2'h2) ? 32'h7 : 32'hf;
    hyb = ~code[2] & ~lin;
    st = 32'h1234_5600 | {24'h0, ofs};
    ex = st;
    base = st & ~msk;
    done = 1'b0;
    cnt = 0;
    apb(1'b1, CFG_OFS, 32'hffff_8f18 | {29'h0, code}, r, e);
    apb(1'b0, CFG_OFS, 32'h0, r, e);
    chk("cfg", 32'h0000_8f18 | {29'h0, code}, r);
    chk("cfg_err", 32'h0, {31'h0, e});
    @(posedge pclk);
    u_host.open_burst({2'h0, lin, st[31:3], 13'h0, st[2:0]});
    wait_av(1'b1);
    chk("start_addr", st, word_addr);
    chk("linear_at_start", {31'h0, lin}, {31'h0, burst_linear});
    for (int i = 0; i < msk + 5; i++) begin
      @(posedge pclk);
      fork
        u_host.step();
        wait_step();
      join
      if (lin || done) ex = ex + 32'h1;
      else begin
        cnt++;
        if (hyb && cnt == msk + 1) begin
          done = 1'b1;
          ex = base + msk + 32'h1;
        end else ex = base | ((ex + 32'h1) & msk);
      end
      chk("word_addr", ex, word_addr);
    end
    apb(1'b0, ADDR_OFS, 32'h0, r, e);
    chk("addr_reg", ex, r);
    apb(1'b0, STAT_OFS, 32'h0, r, e);
    chk("status", {28'h0, lin, ~code[2], lin | done, 1'b1}, r);
    chk("linear_at_end", {31'h0, lin | done}, {31'h0, burst_linear});
    @(posedge pclk);
    u_host.close_burst();
    wait_av(1'b0);
    chk("addr_valid_end", 32'h0, {31'h0, addr_valid});
  endtask

  // Reset, register checks, every configuration code, then a linear burst.
  initial begin
    logic [31:0] r;
    logic e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFS, 32'h0, r, e);
    chk("cfg_reset", {16'h0, CFG_RST}, r);
    chk("cfg_reset_low", 32'h7, {29'h0, r[2:0]});
    apb(1'b0, STAT_OFS, 32'h0, r, e);
    chk("status_reset", 32'h0, r);
    apb(1'b1, 8'h0c, 32'hffff_ffff, r, e);
    chk("unmapped_wr_err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk("unmapped_rd_err", 32'h1, {31'h0, e});
    chk("unmapped_rd_data", 32'h0, r);
    for (int k = 0; k < 8; k++) run(k[2:0], 1'b0, ofs_tab[k]);
    run(3'h0, 1'b1, 8'h03);
    give_verdict();
  end
endmodule
